// ---- pin_change_pkg.sv ----
// Purpose: shared constants for the pin-change edge detector block
// Assumes: APB slave, 32-bit data, one register per aligned word
// Notes: register offsets are byte addresses
package pin_change_pkg;
  localparam int unsigned ADDR_W = 5;
  localparam logic [4:0] OFF_PORTA_RISE = 5'h00;
  localparam logic [4:0] OFF_PORTA_FALL = 5'h04;
  localparam logic [4:0] OFF_PORTA_FLAGS = 5'h08;
  localparam logic [4:0] OFF_PORTB_RISE = 5'h0c;
  localparam logic [4:0] OFF_PORTB_FALL = 5'h10;
  localparam logic [4:0] OFF_PORTB_FLAGS = 5'h14;
  localparam logic [4:0] OFF_CORE_CTRL = 5'h18;
  // implemented bits of each 8-bit port register
  localparam logic [7:0] PORTA_MASK = 8'h3f;
  localparam logic [7:0] PORTB_MASK = 8'hf0;
  localparam logic [7:0] REG_RESET = 8'h00;
  // core interrupt control field positions
  localparam int unsigned CTRL_MASTER_BIT = 3;
  localparam int unsigned CTRL_SUMMARY_BIT = 0;
endpackage : pin_change_pkg

// ---- pin_edge_port.sv ----
// Purpose: edge detection and sticky flags for one 8-bit port
// Assumes: pins are asynchronous; enables and writes come on pclk
// Notes: unimplemented bits are removed by the mask parameter
`timescale 1ns/1ps
module pin_edge_port #(
  parameter logic [7:0] MASK = 8'hff
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] pin,
  input wire logic [7:0] rise_en,
  input wire logic [7:0] fall_en,
  input wire logic flag_wr,
  input wire logic [7:0] flag_wdata,
  output logic [7:0] flags
);
  logic [7:0] sync1_q;
  logic [7:0] sync2_q;
  logic [7:0] prev_q;
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  wire logic [7:0] rise_seen;
  wire logic [7:0] fall_seen;
  wire logic [7:0] edge_hit;
  wire logic [7:0] kept;

  // two-stage synchroniser then one-cycle history for comparison
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
      prev_q <= 8'h00;
    end else begin
      sync1_q <= pin;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // independent rising and falling detectors, each armed by its enable
  assign rise_seen = sync2_q & ~prev_q & rise_en;
  assign fall_seen = ~sync2_q & prev_q & fall_en;
  assign edge_hit = (rise_seen | fall_seen) & MASK;

  // write of zero clears, one keeps; a coincident edge always wins
  assign kept = flag_wr ? (flags_q & flag_wdata) : flags_q;
  assign flags_d = (kept | edge_hit) & MASK;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= 8'h00;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flags = flags_q;
endmodule : pin_edge_port

// ---- pin_change_edge_interrupt.sv ----
// Purpose: pin-change edge detector for two ports with APB registers
// Assumes: pclk 200 MHz, presetn asynchronous active low
// Notes: sleep wake request is a level that follows the interrupt
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
module pin_change_edge_interrupt (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [5:0] porta_pin,
  input wire logic [7:4] portb_pin,
  output logic irq,
  output logic wake_request
);
  logic [7:0] porta_rise_enable_q;
  logic [7:0] porta_fall_enable_q;
  logic [7:0] portb_rise_enable_q;
  logic [7:0] portb_fall_enable_q;
  logic master_enable_q;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic [7:0] porta_edge_flags;
  logic [7:0] portb_edge_flags;
  wire logic [7:0] porta_pins8;
  wire logic [7:0] portb_pins8;
  wire logic [4:0] reg_addr;
  wire logic addr_ok;
  wire logic access;
  wire logic wr;
  wire logic rd;
  wire logic hit_a_rise;
  wire logic hit_a_fall;
  wire logic hit_a_flags;
  wire logic hit_b_rise;
  wire logic hit_b_fall;
  wire logic hit_b_flags;
  wire logic hit_ctrl;
  wire logic mapped;
  wire logic summary_flag;
  wire logic [7:0] ctrl_byte;

  // pins placed at their register bit positions
  assign porta_pins8 = {2'b00, porta_pin};
  assign portb_pins8 = {portb_pin, 4'h0};

  // apb decode: zero wait states, words aligned in a small window
  assign reg_addr = paddr[4:0];
  assign addr_ok = (paddr[31:5] == 27'h0000000) && (paddr[1:0] == 2'b00);
  assign access = psel && penable;
  assign wr = access && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign hit_a_rise = addr_ok && (reg_addr == pin_change_pkg::OFF_PORTA_RISE);
  assign hit_a_fall = addr_ok && (reg_addr == pin_change_pkg::OFF_PORTA_FALL);
  assign hit_a_flags = addr_ok &&
    (reg_addr == pin_change_pkg::OFF_PORTA_FLAGS);
  assign hit_b_rise = addr_ok && (reg_addr == pin_change_pkg::OFF_PORTB_RISE);
  assign hit_b_fall = addr_ok && (reg_addr == pin_change_pkg::OFF_PORTB_FALL);
  assign hit_b_flags = addr_ok &&
    (reg_addr == pin_change_pkg::OFF_PORTB_FLAGS);
  assign hit_ctrl = addr_ok && (reg_addr == pin_change_pkg::OFF_CORE_CTRL);
  assign mapped = hit_a_rise || hit_a_fall || hit_a_flags || hit_b_rise ||
    hit_b_fall || hit_b_flags || hit_ctrl;
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  // per-port edge detection and sticky flags
  pin_edge_port #(.MASK(pin_change_pkg::PORTA_MASK)) u_porta (
    .pclk(pclk),
    .presetn(presetn),
    .pin(porta_pins8),
    .rise_en(porta_rise_enable_q),
    .fall_en(porta_fall_enable_q),
    .flag_wr(wr && hit_a_flags),
    .flag_wdata(pwdata[7:0]),
    .flags(porta_edge_flags)
  );

  pin_edge_port #(.MASK(pin_change_pkg::PORTB_MASK)) u_portb (
    .pclk(pclk),
    .presetn(presetn),
    .pin(portb_pins8),
    .rise_en(portb_rise_enable_q),
    .fall_en(portb_fall_enable_q),
    .flag_wr(wr && hit_b_flags),
    .flag_wdata(pwdata[7:0]),
    .flags(portb_edge_flags)
  );

  // summary and request outputs; flags are live before any wakeup
  assign summary_flag = |{porta_edge_flags, portb_edge_flags};
  assign irq = master_enable_q && summary_flag;
  assign wake_request = master_enable_q && summary_flag;

  // core interrupt control view: master enable and summary flag
  assign ctrl_byte = (8'h01 << pin_change_pkg::CTRL_MASTER_BIT) &
    {8{master_enable_q}} |
    (8'h01 << pin_change_pkg::CTRL_SUMMARY_BIT) & {8{summary_flag}};

  // enable registers, unimplemented bits held at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      porta_rise_enable_q <= pin_change_pkg::REG_RESET;
      porta_fall_enable_q <= pin_change_pkg::REG_RESET;
      portb_rise_enable_q <= pin_change_pkg::REG_RESET;
      portb_fall_enable_q <= pin_change_pkg::REG_RESET;
      master_enable_q <= 1'b0;
    end else if (wr) begin
      if (hit_a_rise) begin
        porta_rise_enable_q <= pwdata[7:0] & pin_change_pkg::PORTA_MASK;
      end
      if (hit_a_fall) begin
        porta_fall_enable_q <= pwdata[7:0] & pin_change_pkg::PORTA_MASK;
      end
      if (hit_b_rise) begin
        portb_rise_enable_q <= pwdata[7:0] & pin_change_pkg::PORTB_MASK;
      end
      if (hit_b_fall) begin
        portb_fall_enable_q <= pwdata[7:0] & pin_change_pkg::PORTB_MASK;
      end
      if (hit_ctrl) begin
        master_enable_q <= pwdata[pin_change_pkg::CTRL_MASTER_BIT];
      end
    end
  end

  // read mux, captured in the setup cycle
  always_comb begin
    prdata_d = prdata_q;
    if (rd) begin
      prdata_d = 32'h00000000;
      if (hit_a_rise) prdata_d[7:0] = porta_rise_enable_q;
      if (hit_a_fall) prdata_d[7:0] = porta_fall_enable_q;
      if (hit_a_flags) prdata_d[7:0] = porta_edge_flags;
      if (hit_b_rise) prdata_d[7:0] = portb_rise_enable_q;
      if (hit_b_fall) prdata_d[7:0] = portb_fall_enable_q;
      if (hit_b_flags) prdata_d[7:0] = portb_edge_flags;
      if (hit_ctrl) prdata_d[7:0] = ctrl_byte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  assign prdata = prdata_q;
endmodule : pin_change_edge_interrupt

// ---- pin_change_properties.sv ----
// Purpose: port checks of the pin-change block
// Assumes: one pclk domain, presetn async active low
// Notes: bound to the top module
`timescale 1ns/1ps
module pin_change_properties (
  input wire logic pclk, presetn, psel, penable, pwrite, pready,
  input wire logic [31:0] paddr, pwdata, prdata,
  input wire logic pslverr, irq, wake_request,
  input wire logic [5:0] porta_pin,
  input wire logic [7:4] portb_pin
);
  // access decode and joined pins
  wire logic rd_acc = psel && penable && !pwrite;
  wire logic wr_acc = psel && penable && pwrite;
  wire logic [9:0] pins = {portb_pin, porta_pin};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // interrupt level, its causes and releases
  wake_match_a: assert property (wake_request == irq)
    else $error("wake differs from irq");
  irq_cause_a: assert property ($rose(irq) |->
    $past(wr_acc) || $past(pins, 3) != $past(pins, 4))
    else $error("irq rose without cause");
  irq_drop_a: assert property ($fell(irq) |-> $past(wr_acc))
    else $error("irq fell without a write");
  // refusals and read data
  bad_addr_a: assert property (psel && penable && paddr > 32'h1b |-> pslverr)
    else $error("unmapped access accepted");
  err_zero_a: assert property (rd_acc && pslverr |-> prdata == '0)
    else $error("refused read not zero");
  porta_bits_a: assert property (
    rd_acc && paddr < 32'h0c |-> prdata[31:6] == '0)
    else $error("port a spare bits set");
  portb_bits_a: assert property (
    rd_acc && paddr inside {[32'h0c:32'h14]} |->
    prdata[31:8] == '0 && prdata[3:0] == '0)
    else $error("port b spare bits set");
  rdata_hold_a: assert property (
    !(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved");
endmodule : pin_change_properties

bind pin_change_edge_interrupt pin_change_properties u_props (.*);

// ---- pin_source.sv ----
// Purpose: far-side pins following a commanded pattern
// Assumes: one change per pclk edge
// Notes: one cycle of lag stands for the outside wiring
`timescale 1ns/1ps
module pin_source (
  input wire logic pclk,
  input wire logic [9:0] target,
  output logic [5:0] porta_pin,
  output logic [7:4] portb_pin
);
  // drive both ports from the pattern
  always @(posedge pclk) begin
    {portb_pin, porta_pin} <= target;
  end
endmodule : pin_source

// ---- tb_top.sv ----
// Purpose: self-checking bench for the pin-change block
// Assumes: APB master on pclk rising edges
// Notes: each read also checks irq and wake levels
`timescale 1ns/1ps
module tb_top;
  logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, r;
  logic pready, pslverr, irq, wake_request;
  logic [5:0] porta_pin;
  logic [7:4] portb_pin;
  logic [9:0] target = '0;
  logic [33:0] exp_q[$];
  int err_count = 0, checks = 0, cyc = 0, seed = 63;
  // 200 MHz clock
  always #2.5 pclk = ~pclk;
  pin_change_edge_interrupt uut (.*);
  pin_source pins_far (.*);
  // compare a seen value with its note
  task automatic chk(input logic [33:0] s, e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // counts, verdict, stop
  task automatic final_report();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  // one transfer, held until pready
  task automatic apb(input logic [31:0] a, d, input logic w);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (!pready);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // note expected data and irq, then read
  task automatic rd(input logic [31:0] a, d, input logic i);
    exp_q.push_back({i, i, d});
    apb(a, '0, 1'b0);
  endtask : rd
  // move pins, check flags and summary, clear
  task automatic pulse(input logic [9:0] v, input logic e);
    target <= v;
    repeat (6) @(posedge pclk);
    rd(32'h08, {8{e}} & 8'h3f, 1'b0);
    rd(32'h14, {8{e}} & 8'hf0, 1'b0);
    rd(32'h18, {31'h0, e}, 1'b0);
    apb(32'h08, '0, 1'b1);
    apb(32'h14, '0, 1'b1);
  endtask : pulse
  // watch reads against the oldest note; cut a hang
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready)
      chk({wake_request, irq, prdata}, exp_q.pop_front());
    // every access: always ready, refused only outside the register map
    if (psel && penable)
      chk({pready, pslverr}, {1'b1, paddr > 32'h18});
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      final_report();
    end
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(32'h1c, '1, 1'b1);
    for (int a = 0; a < 32; a += 4) rd(a, '0, 1'b0);
    $display("test reset done");
    // random enables keep only implemented bits
    for (int a = 0; a < 20; a += 4) begin
      if (a == 8) continue;
      r = $random(seed);
      apb(a, r, 1'b1);
      rd(a, r & (a < 8 ? 32'h3f : 32'hf0), 1'b0);
    end
    $display("test masks done");
    // every mix of rise and fall enables
    for (int md = 0; md < 4; md++) begin
      apb(32'h00, {32{md[0]}}, 1'b1);
      apb(32'h0c, {32{md[0]}}, 1'b1);
      apb(32'h04, {32{md[1]}}, 1'b1);
      apb(32'h10, {32{md[1]}}, 1'b1);
      pulse(10'h3ff, md[0]);
      pulse(10'h000, md[1]);
    end
    $display("test modes done");
    // master enable, keep on one, edge during clear
    apb(32'h18, 32'h08, 1'b1);
    target <= 10'h001;
    repeat (6) @(posedge pclk);
    rd(32'h08, 32'h01, 1'b1);
    rd(32'h18, 32'h09, 1'b1);
    apb(32'h08, '1, 1'b1);
    rd(32'h08, 32'h01, 1'b1);
    target <= 10'h003;
    repeat (2) @(posedge pclk);
    apb(32'h08, 32'hfe, 1'b1);
    rd(32'h08, 32'h02, 1'b1);
    apb(32'h08, '0, 1'b1);
    rd(32'h18, 32'h08, 1'b0);
    $display("test master done");
    final_report();
  end
endmodule : tb_top
